// [inc/ier_regs.svh]
// Constants for the interrupt entry and return sequencer
`ifndef IER_REGS_SVH
`define IER_REGS_SVH
`define SP_RESET 16'h00ff
`define TRAP_OPCODE 8'hff
`define ACCEPT_CYCLES 8
`define FRAME_BYTES 16'h0003
`define ST_GIE 7
`define ST_BANK 0
`define SRC_TRAP 5'h00
`define SRC_UNDEF 5'h01
`define SRC_LATCH0 5'h02
`define RF_BYTES 12
`define RF_IDX_W 4
`endif

// [inc/ier_pkg.sv]
// Types shared by the interrupt entry and return sequencer
`include "ier_regs.svh"
package ier_pkg;
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_ENTRY = 4'h1,
        S_PUSH_ST = 4'h2,
        S_PUSH_HI = 4'h3,
        S_PUSH_LO = 4'h4,
        S_VLO = 4'h5,
        S_VHI = 4'h6,
        S_VCAP = 4'h7,
        S_JUMP = 4'h8,
        S_RA = 4'h9,
        S_RB = 4'ha,
        S_RC = 4'hb,
        S_RD = 4'hc,
        S_RE = 4'hd
    } seq_state_type;
    typedef struct packed {
        logic we;
        logic re;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mem_req_type;
    typedef struct packed {
        logic push;
        logic pop;
        logic [7:0] data;
    } stack_op_type;
    typedef struct packed {
        logic gie_wr;
        logic gie_val;
        logic bank_wr;
        logic bank_val;
        logic sp_wr;
        logic [15:0] sp_val;
    } sw_ctrl_type;
    typedef struct packed {
        logic we;
        logic [`RF_IDX_W-1:0] idx;
        logic [7:0] wdata;
    } rf_acc_type;
    typedef struct packed {
        seq_state_type seq;
        logic [15:0] sp;
        logic [15:0] pc;
        logic [7:0] stat;
        logic [7:0] saved_stat;
        logic [4:0] src;
        logic [7:0] vec_lo;
        logic nmi_act;
        logic ret_nm;
        mem_req_type mem;
        logic stack_rd;
        logic pc_load;
        logic [7:0] opcode;
        logic addr_err;
    } core_state_type;
    typedef struct packed {
        logic [1:0][`RF_BYTES-1:0][7:0] cells;
        logic [7:0] rdata;
    } rf_state_type;
endpackage

// [logic/irq_latch_array.sv]
// Pending request latches, one per interrupt source
`timescale 1ns/100ps
module irq_latch_array
    import ier_pkg::*;
#(
    parameter int NUM_SRC = 8
) (
    input wire logic core_clk, // Machine clock
    input wire logic reset_n, // Async reset
    input wire logic [NUM_SRC-1:0] set_req, // Request pulses
    input wire logic [NUM_SRC-1:0] clr_sw, // Software clear
    input wire logic [NUM_SRC-1:0] clr_acc, // Clear on acceptance
    output logic [NUM_SRC-1:0] pending // Held requests
);
    typedef struct packed {
        logic [NUM_SRC-1:0] pend;
    } latch_state_type;
    latch_state_type s_r, s_nxt;

    // hold until cleared; a new request beats a clear
    always_comb begin
        s_nxt.pend = (s_r.pend & ~clr_sw & ~clr_acc) | set_req;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pending = s_r.pend;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_latch_holds: assert property ((|(s_r.pend & ~clr_sw & ~clr_acc)) |=>
        ((s_r.pend & $past(s_r.pend & ~clr_sw & ~clr_acc)) == $past(s_r.pend & ~clr_sw & ~clr_acc)))
        else $error("held request lost");
    a_accept_clears: assert property ((|(clr_acc & ~set_req)) |=>
        ((s_r.pend & $past(clr_acc & ~set_req)) == '0))
        else $error("accepted latch not cleared");
endmodule // irq_latch_array

// [logic/reg_bank_file.sv]
// Two switchable banks of general and index registers
`timescale 1ns/100ps
module reg_bank_file
    import ier_pkg::*;
(
    input wire logic core_clk, // Machine clock
    input wire logic reset_n, // Async reset
    input wire logic bank_sel, // Active bank
    input wire rf_acc_type acc, // Write or read access
    output logic [7:0] rdata // Read byte, next cycle
);
    rf_state_type s_r, s_nxt;

    // eight bytes plus two 16-bit index pairs per bank
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = 8'h00;
        if (acc.idx < `RF_IDX_W'(`RF_BYTES)) begin
            s_nxt.rdata = s_r.cells[bank_sel][acc.idx];
            if (acc.we) begin
                s_nxt.cells[bank_sel][acc.idx] = acc.wdata;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
endmodule // reg_bank_file

// [logic/cpu_interrupt_entry_return.sv]
// Interrupt entry and return sequencer with stack pointer and status word
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/100ps
`include "ier_regs.svh"
// Contract
// - Stack pointer is 16 bits, decremented after every byte pushed.
// - Stack pointer is incremented before every byte popped.
// - Reset loads the stack pointer with 00FFH.
// - Acceptance first clears the global enable flag.
// - Acceptance clears the latch of the accepted source.
// - Acceptance pushes status word, PC high, PC low; pointer drops by three.
// - PC then loads the vector slot entry and runs from there.
// - The saved status word holds bank select and global enable.
// - No maskable acceptance until software or a return of the saved status word sets the global enable again.
// - Only PC and status word are saved; general registers stay untouched.
// - Two banks, each eight byte registers and two 16-bit index registers.
// - Maskable return restores bank select from the popped status word.
// - Both returns pop PC and status word; pointer rises by three.
// - Software trap starts entry at once, above every source but the undefined opcode.
// - Fetch from a missing address reads FFH, the trap, flagging an error.
// - Undefined opcode raises its own interrupt through its vector.
// - Undefined opcode aborts any sequence, even non-maskable service.
// - Entry takes eight machine cycles after the current instruction ends.
// - A latched request holds until acceptance, reset or a clear.
module cpu_interrupt_entry_return
    import ier_pkg::*;
#(
    parameter int NUM_SRC = 8, // Latch bit 0 is the non-maskable source
    parameter logic [15:0] VEC_BASE = 16'hffc0 // Vector table base
) (
    input wire logic core_clk, // Machine clock
    input wire logic reset_n, // Async reset
    input wire logic instr_done, // Current instruction completes
    input wire logic fetch_valid, // Opcode fetch this cycle
    input wire logic fetch_addr_ok, // Fetch address exists
    input wire logic [7:0] fetch_byte, // Raw fetched byte
    input wire logic undef_exec, // Decoder met an undefined opcode
    input wire logic irq_ret_exec, // Maskable return executes
    input wire logic nmi_ret_exec, // Non-maskable return executes
    input wire logic [15:0] pc_cur, // Return address to save
    input wire stack_op_type stk, // Push or pop by calls and pushes
    input wire sw_ctrl_type sw, // Software writes to flags and pointer
    input wire logic [NUM_SRC-1:0] irq_req, // Source request pulses
    input wire logic [NUM_SRC-1:0] irq_enable, // Per-source enables
    input wire logic [NUM_SRC-1:0] latch_clr, // Software latch clears
    input wire rf_acc_type rf_acc, // Register bank access
    input wire logic [7:0] mem_rdata, // Data memory read byte
    output mem_req_type mem_req, // Data memory request
    output logic [15:0] pc_out, // Program counter
    output logic pc_load, // Pulse: jump to pc_out
    output logic [15:0] sp_out, // Stack pointer
    output logic [7:0] status_out, // Status word
    output logic nmi_busy, // Non-maskable service active
    output logic [7:0] opcode_out, // Opcode after substitution
    output logic addr_error, // Last fetch hit a missing address
    output logic [7:0] rf_rdata // Register bank read byte
);
    core_state_type s_r, s_nxt;
    logic [NUM_SRC-1:0] pend;
    logic [NUM_SRC-1:0] clr_acc;
    logic [NUM_SRC-1:0] masked;
    logic accept_start;
    logic ret_start;
    logic trap_hit;
    logic [4:0] acc_src;
    logic [7:0] fetched;

    function automatic logic [4:0] low_idx(input logic [NUM_SRC-1:0] v);
        low_idx = 5'h00;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                low_idx = 5'(i);
            end
        end
    endfunction

    function automatic logic [15:0] slot_addr(input logic [4:0] src);
        slot_addr = VEC_BASE + {10'h000, src, 1'b0};
    endfunction

    function automatic mem_req_type wr_req(input logic [15:0] a, input logic [7:0] d);
        wr_req = '0;
        wr_req.we = 1'b1;
        wr_req.addr = a;
        wr_req.wdata = d;
    endfunction

    function automatic mem_req_type rd_req(input logic [15:0] a);
        rd_req = '0;
        rd_req.re = 1'b1;
        rd_req.addr = a;
    endfunction

    irq_latch_array #(
        .NUM_SRC(NUM_SRC)
    ) u_latch (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .set_req(irq_req),
        .clr_sw(latch_clr),
        .clr_acc(clr_acc),
        .pending(pend)
    );

    // bank contents never touched by the sequencer
    reg_bank_file u_banks (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .bank_sel(s_r.stat[`ST_BANK]),
        .acc(rf_acc),
        .rdata(rf_rdata)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.mem = '0;
        s_nxt.stack_rd = 1'b0;
        s_nxt.pc_load = 1'b0;
        clr_acc = '0;
        accept_start = 1'b0;
        ret_start = 1'b0;
        acc_src = `SRC_TRAP;
        masked = pend & irq_enable & ~NUM_SRC'(1);
        // missing address reads as the trap opcode
        fetched = fetch_addr_ok ? fetch_byte : `TRAP_OPCODE;
        trap_hit = fetch_valid && (fetched == `TRAP_OPCODE);
        if (fetch_valid) begin
            s_nxt.opcode = fetched;
            s_nxt.addr_err = !fetch_addr_ok;
        end
        // Sequence steps below override these writes
        if (sw.gie_wr) begin
            s_nxt.stat[`ST_GIE] = sw.gie_val;
        end
        if (sw.bank_wr) begin
            s_nxt.stat[`ST_BANK] = sw.bank_val;
        end
        if (sw.sp_wr) begin
            s_nxt.sp = sw.sp_val;
        end
        // undefined opcode enters through its own vector
        // abort whatever runs, even non-maskable service
        if (undef_exec) begin
            accept_start = 1'b1;
            acc_src = `SRC_UNDEF;
        end else if (s_r.seq == S_IDLE) begin
            // trap wins over every latched source
            if (trap_hit) begin
                accept_start = 1'b1;
            // latched sources wait for the instruction end
            end else if (instr_done && pend[0] && !s_r.nmi_act) begin
                accept_start = 1'b1;
                acc_src = `SRC_LATCH0;
            // maskable sources need the global enable
            end else if (instr_done && s_r.stat[`ST_GIE] && (|masked)) begin
                accept_start = 1'b1;
                acc_src = `SRC_LATCH0 + low_idx(masked);
            end
        end
        if (accept_start) begin
            s_nxt.seq = S_ENTRY;
            s_nxt.src = acc_src;
            s_nxt.pc = pc_cur;
            // snapshot keeps bank and enable as they were
            s_nxt.saved_stat = s_nxt.stat;
        end else begin
            case (s_r.seq)
                S_IDLE: begin
                    if (irq_ret_exec || nmi_ret_exec) begin
                        ret_start = 1'b1;
                        s_nxt.ret_nm = nmi_ret_exec;
                        s_nxt.seq = S_RA;
                    end else if (stk.push) begin
                        s_nxt.mem = wr_req(s_r.sp, stk.data);
                        s_nxt.sp = s_r.sp - 16'h0001;
                    end else if (stk.pop) begin
                        s_nxt.mem = rd_req(s_r.sp + 16'h0001);
                        s_nxt.sp = s_r.sp + 16'h0001;
                        s_nxt.stack_rd = 1'b1;
                    end
                end
                S_ENTRY: begin
                    s_nxt.stat[`ST_GIE] = 1'b0;
                    if (s_r.src >= `SRC_LATCH0) begin
                        clr_acc = NUM_SRC'(1) << (s_r.src - `SRC_LATCH0);
                    end
                    if (s_r.src <= `SRC_LATCH0) begin
                        s_nxt.nmi_act = 1'b1;
                    end
                    s_nxt.seq = S_PUSH_ST;
                end
                // status word, PC high, PC low
                S_PUSH_ST: begin
                    s_nxt.mem = wr_req(s_r.sp, s_r.saved_stat);
                    s_nxt.sp = s_r.sp - 16'h0001;
                    s_nxt.seq = S_PUSH_HI;
                end
                S_PUSH_HI: begin
                    s_nxt.mem = wr_req(s_r.sp, s_r.pc[15:8]);
                    s_nxt.sp = s_r.sp - 16'h0001;
                    s_nxt.seq = S_PUSH_LO;
                end
                S_PUSH_LO: begin
                    s_nxt.mem = wr_req(s_r.sp, s_r.pc[7:0]);
                    s_nxt.sp = s_r.sp - 16'h0001;
                    s_nxt.seq = S_VLO;
                end
                // Vector slot: low byte first, high byte next
                S_VLO: begin
                    s_nxt.mem = rd_req(slot_addr(s_r.src));
                    s_nxt.seq = S_VHI;
                end
                S_VHI: begin
                    s_nxt.mem = rd_req(slot_addr(s_r.src) + 16'h0001);
                    s_nxt.seq = S_VCAP;
                end
                S_VCAP: begin
                    s_nxt.vec_lo = mem_rdata;
                    s_nxt.seq = S_JUMP;
                end
                S_JUMP: begin
                    s_nxt.pc = {mem_rdata, s_r.vec_lo};
                    s_nxt.pc_load = 1'b1;
                    s_nxt.seq = S_IDLE;
                end
                // pop PC low, PC high, status word
                S_RA: begin
                    s_nxt.mem = rd_req(s_r.sp + 16'h0001);
                    s_nxt.sp = s_r.sp + 16'h0001;
                    s_nxt.stack_rd = 1'b1;
                    s_nxt.seq = S_RB;
                end
                S_RB: begin
                    s_nxt.mem = rd_req(s_r.sp + 16'h0001);
                    s_nxt.sp = s_r.sp + 16'h0001;
                    s_nxt.stack_rd = 1'b1;
                    s_nxt.seq = S_RC;
                end
                S_RC: begin
                    s_nxt.mem = rd_req(s_r.sp + 16'h0001);
                    s_nxt.sp = s_r.sp + 16'h0001;
                    s_nxt.stack_rd = 1'b1;
                    s_nxt.pc[7:0] = mem_rdata;
                    s_nxt.seq = S_RD;
                end
                S_RD: begin
                    s_nxt.pc[15:8] = mem_rdata;
                    s_nxt.seq = S_RE;
                end
                // popped word brings back the bank
                S_RE: begin
                    s_nxt.stat = mem_rdata;
                    s_nxt.pc_load = 1'b1;
                    if (s_r.ret_nm) begin
                        s_nxt.nmi_act = 1'b0;
                    end
                    s_nxt.seq = S_IDLE;
                end
                default: begin
                    s_nxt.seq = S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
            s_r.sp <= `SP_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign mem_req = s_r.mem;
    assign pc_out = s_r.pc;
    assign pc_load = s_r.pc_load;
    assign sp_out = s_r.sp;
    assign status_out = s_r.stat;
    assign nmi_busy = s_r.nmi_act;
    assign opcode_out = s_r.opcode;
    assign addr_error = s_r.addr_err;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_push_post_dec: assert property (s_r.mem.we |-> (s_r.sp == s_r.mem.addr - 16'h0001))
        else $error("push did not post-decrement");
    a_pop_pre_inc: assert property (s_r.stack_rd |-> (s_r.sp == s_r.mem.addr))
        else $error("pop did not pre-increment");
    a_entry_gie_clr: assert property ((s_r.seq == S_ENTRY && !undef_exec) |=> !s_r.stat[`ST_GIE])
        else $error("enable flag not cleared on entry");
    a_push_order: assert property ((s_r.seq == S_PUSH_ST && !undef_exec) ##1 !undef_exec |->
        (s_r.mem.we && s_r.mem.wdata == $past(s_r.saved_stat))
        ##1 (s_r.mem.we && s_r.mem.wdata == s_r.pc[15:8] && s_r.mem.addr == $past(s_r.mem.addr) - 16'h0001))
        else $error("wrong push order");
    a_mask_gate: assert property ((accept_start && acc_src > `SRC_LATCH0) |-> s_r.stat[`ST_GIE])
        else $error("maskable accepted with enable clear");
    a_entry_len: assert property (accept_start ##1 (!undef_exec [*8]) |=> pc_load)
        else $error("entry not eight cycles");
    a_ret_sp: assert property (ret_start ##1 (!undef_exec [*5]) |=>
        (s_r.sp == $past(s_r.sp, 6) + `FRAME_BYTES))
        else $error("return did not add three");
    a_bank_restore: assert property ((s_r.seq == S_RE && !undef_exec) |=>
        (s_r.stat[`ST_BANK] == $past(mem_rdata[`ST_BANK])))
        else $error("bank not restored");
    a_undef_abort: assert property (undef_exec |=> (s_r.seq == S_ENTRY && s_r.src == `SRC_UNDEF))
        else $error("undefined opcode not taken at once");
    a_fetch_trap: assert property ((fetch_valid && !fetch_addr_ok && !undef_exec) |=>
        (opcode_out == `TRAP_OPCODE && addr_error && s_r.seq == S_ENTRY && s_r.src == `SRC_TRAP))
        else $error("missing address did not trap");
    a_trap_first: assert property ((trap_hit && !undef_exec && s_r.seq == S_IDLE) |=>
        (s_r.src == `SRC_TRAP))
        else $error("trap lost priority");
endmodule // cpu_interrupt_entry_return

// [verif/stack_memory_model.sv]
// Behavioural data memory holding the stack and the vector table
`timescale 1ns/100ps
module stack_memory_model
    import ier_pkg::*;
#(
    parameter logic [15:0] VEC_BASE = 16'hffc0 // Vector table base
) (
    input wire logic core_clk, // Machine clock
    input wire mem_req_type mem_req, // Byte request
    output logic [7:0] mem_rdata // Read byte, next cycle
);
    logic [7:0] mem [0:65535];
    initial begin
        mem_rdata = 8'h00;
        for (int i = 0; i < 32; i++) begin
            mem[VEC_BASE + 16'(2 * i)] = 8'(4 * i);
            mem[VEC_BASE + 16'(2 * i + 1)] = 8'(8'h80 + i);
        end
    end
    // stack bytes
    // Plain always: the preload writes the same array
    always @(posedge core_clk) begin
        if (mem_req.we) begin
            mem[mem_req.addr] <= mem_req.wdata;
        end
        // Idle bus toggles so stale data never passes as valid
        mem_rdata <= mem_req.re ? mem[mem_req.addr] : ~mem_rdata;
    end
endmodule // stack_memory_model

// [verif/tb.sv]
// Self-checking bench of the interrupt entry and return sequencer
`timescale 1ns/100ps
`define CHK(g, e) check_val(16'(g), 16'(e))
module tb
    import ier_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic instr_done = 1'b0, fetch_valid = 1'b0, fetch_addr_ok = 1'b1, undef_exec = 1'b0;
    logic irq_ret_exec = 1'b0, nmi_ret_exec = 1'b0;
    logic [7:0] fetch_byte = 8'h00, irq_req = 8'h00, irq_enable = 8'h00, latch_clr = 8'h00;
    logic [15:0] pc_cur = 16'h1234;
    stack_op_type stk = '0;
    sw_ctrl_type sw = '0;
    rf_acc_type rf_acc = '0;
    logic [7:0] mem_rdata, status_out, opcode_out, rf_rdata;
    mem_req_type mem_req;
    logic [15:0] pc_out, sp_out;
    logic pc_load, nmi_busy, addr_error;
    int miscompares = 0;
    int check_count = 0;

    cpu_interrupt_entry_return i_dut (.core_clk(core_clk), .reset_n(reset_n), .instr_done(instr_done),
        .fetch_valid(fetch_valid), .fetch_addr_ok(fetch_addr_ok), .fetch_byte(fetch_byte),
        .undef_exec(undef_exec), .irq_ret_exec(irq_ret_exec), .nmi_ret_exec(nmi_ret_exec), .pc_cur(pc_cur),
        .stk(stk), .sw(sw), .irq_req(irq_req), .irq_enable(irq_enable), .latch_clr(latch_clr),
        .rf_acc(rf_acc), .mem_rdata(mem_rdata), .mem_req(mem_req), .pc_out(pc_out), .pc_load(pc_load),
        .sp_out(sp_out), .status_out(status_out), .nmi_busy(nmi_busy), .opcode_out(opcode_out),
        .addr_error(addr_error), .rf_rdata(rf_rdata));
    stack_memory_model i_mem (.core_clk(core_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    task automatic stop_test();
        $display("checks %0d, miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] vec(int s);
        return {8'(8'h80 + s), 8'(4 * s)};
    endfunction

    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Bounded wait for the jump; a hang ends the run
    task automatic wait_load(int cnt, logic [15:0] pc);
        int n;
        // Called just after the take edge, which counts as cycle one
        n = 1;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (pc_load !== 1'b1 && n < 20);
        `CHK(n, cnt);
        `CHK(pc_out, pc);
        if (n == 20) begin
            stop_test();
        end
    endtask

    // One-cycle strobe: 0 done, 1 undefined, 2 maskable return, 3 other return, 4 fetch
    task automatic go(int k);
        @(posedge core_clk);
        case (k)
            0: instr_done <= 1'b1;
            1: undef_exec <= 1'b1;
            2: irq_ret_exec <= 1'b1;
            3: nmi_ret_exec <= 1'b1;
            default: fetch_valid <= 1'b1;
        endcase
        @(posedge core_clk);
        {instr_done, undef_exec, irq_ret_exec, nmi_ret_exec, fetch_valid} <= '0;
    endtask

    task automatic req(int b);
        @(posedge core_clk);
        irq_req <= 8'(1 << b);
        @(posedge core_clk);
        irq_req <= 8'h00;
    endtask

    task automatic swr(sw_ctrl_type v);
        @(posedge core_clk);
        sw <= v;
        @(posedge core_clk);
        sw <= '0;
    endtask

    task automatic rf_op(logic we, logic [3:0] i, logic [7:0] d);
        @(posedge core_clk);
        rf_acc <= '{we: we, idx: i, wdata: d};
        @(posedge core_clk);
        rf_acc <= '0;
        #1;
    endtask

    initial begin
        tick(2);
        reset_n <= 1'b1;
        #1;
        `CHK(sp_out, 16'h00ff);
        `CHK(status_out, 8'h00);
        rf_op(1'b1, 4'h0, 8'haa);
        swr('{default: '0, gie_wr: 1'b1, gie_val: 1'b1, bank_wr: 1'b1, bank_val: 1'b1});
        rf_op(1'b1, 4'hb, 8'h55);
        irq_enable <= 8'h08;
        req(3);
        go(0);
        wait_load(9, vec(5));
        `CHK(status_out[7], 1'b0);
        `CHK(i_mem.mem[16'h00ff], 8'h81);
        `CHK(i_mem.mem[16'h00fe], 8'h12);
        `CHK(i_mem.mem[16'h00fd], 8'h34);
        `CHK(sp_out, 16'h00fc);
        irq_enable <= 8'h18;
        req(4);
        go(0);
        repeat (12) begin
            @(posedge core_clk);
            #1;
            `CHK(pc_load, 1'b0);
        end
        swr('{default: '0, bank_wr: 1'b1, bank_val: 1'b0});
        rf_op(1'b0, 4'h0, 8'h00);
        `CHK(rf_rdata, 8'haa);
        go(2);
        wait_load(6, 16'h1234);
        `CHK(status_out, 8'h81);
        `CHK(sp_out, 16'h00ff);
        rf_op(1'b0, 4'hb, 8'h00);
        `CHK(rf_rdata, 8'h55);
        go(0);
        wait_load(9, vec(6));
        // own source masked before the global enable returns
        irq_enable <= 8'h08;
        swr('{default: '0, gie_wr: 1'b1, gie_val: 1'b1});
        req(3);
        go(0);
        wait_load(9, vec(5));
        go(2);
        wait_load(6, 16'h1234);
        `CHK(sp_out, 16'h00fc);
        go(2);
        wait_load(6, 16'h1234);
        @(posedge core_clk);
        stk <= '{push: 1'b1, pop: 1'b0, data: 8'h5a};
        @(posedge core_clk);
        stk <= '{push: 1'b0, pop: 1'b1, data: 8'h00};
        @(posedge core_clk);
        stk <= '0;
        #1;
        `CHK(i_mem.mem[16'h00ff], 8'h5a);
        tick(2);
        #1;
        `CHK(sp_out, 16'h00ff);
        fetch_byte <= 8'hff;
        go(4);
        wait_load(9, vec(0));
        `CHK(addr_error, 1'b0);
        go(3);
        wait_load(6, 16'h1234);
        fetch_byte <= 8'h00;
        fetch_addr_ok <= 1'b0;
        go(4);
        fetch_addr_ok <= 1'b1;
        wait_load(9, vec(0));
        `CHK(opcode_out, 8'hff);
        `CHK(addr_error, 1'b1);
        go(3);
        wait_load(6, 16'h1234);
        go(1);
        wait_load(9, vec(1));
        go(3);
        wait_load(6, 16'h1234);
        @(posedge core_clk);
        reset_n <= 1'b0;
        tick(2);
        reset_n <= 1'b1;
        swr('{default: '0, sp_wr: 1'b1, sp_val: 16'h0240});
        #1;
        `CHK(sp_out, 16'h0240);
        req(0);
        go(0);
        tick(3);
        #1;
        `CHK(nmi_busy, 1'b1);
        go(1);
        wait_load(9, vec(1));
        go(3);
        wait_load(6, 16'h1234);
        `CHK(nmi_busy, 1'b0);
        stop_test();
    end
endmodule // tb
